// [rtl/gpio_port_pkg.sv]
package gpio_port_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [11:0] FUNC_SELECT_OFFSET = 12'h418;
   localparam logic [11:0] DIR_CONFIG_OFFSET  = 12'h41C;
   localparam logic [11:0] LEVEL_DATA_OFFSET  = 12'h420;

   // ------------------------------------------------------------
   // widths and reset values
   // ------------------------------------------------------------
   localparam int          PIN_COUNT       = 16;
   localparam int          DATA_WIDTH      = 32;
   localparam int          ADDR_WIDTH      = 12;
   localparam logic [15:0] FUNC_RESET      = 16'h0000;
   localparam logic [15:0] DIR_RESET       = 16'h0000;
   localparam logic [15:0] OUT_DATA_RESET  = 16'h0000;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

   typedef struct packed {
      logic [15:0] funcSel;
      logic [15:0] dirCfg;
      logic [15:0] outData;
   } gpio_ctrl_t;

endpackage

// [rtl/gpio_apb_slave.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// apb slave: zero wait state, flags accesses to the three words
// ------------------------------------------------------------
module gpio_apb_slave (
   // bus
   input  wire gpio_port_pkg::apb_req_t req,
   output gpio_port_pkg::apb_rsp_t      rsp,
   // register side
   input  wire logic [31:0]             readData,
   output logic                         wrFunc,
   output logic                         wrDir,
   output logic                         wrData,
   output logic                         rdHit
);

   logic access;
   logic hitFunc;
   logic hitDir;
   logic hitData;

   always_comb begin
      access  = req.psel && req.penable;
      hitFunc = req.paddr == gpio_port_pkg::FUNC_SELECT_OFFSET;
      hitDir  = req.paddr == gpio_port_pkg::DIR_CONFIG_OFFSET;
      hitData = req.paddr == gpio_port_pkg::LEVEL_DATA_OFFSET;
      rdHit   = hitFunc || hitDir || hitData;
      wrFunc  = access && req.pwrite && hitFunc;
      wrDir   = access && req.pwrite && hitDir;
      wrData  = access && req.pwrite && hitData;
      rsp.pready  = 1'b1;
      // unmapped address answers with an error and zero data
      rsp.pslverr = access && !rdHit;
      rsp.prdata  = (access && !req.pwrite && rdHit) ? readData : 32'h0000_0000;
   end

endmodule
`default_nettype wire

// [rtl/gpio_pin_cell.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// one pin: mux between plain i/o and alternate function
// ------------------------------------------------------------
module gpio_pin_cell (
   // control
   input  wire logic funcSel,
   input  wire logic dirOut,
   input  wire logic outBit,
   // alternate function
   input  wire logic altOut,
   input  wire logic altOeN,
   // pin
   output logic      pinOut,
   output logic      pinOeN
);

   always_comb begin
      if (funcSel) begin
         pinOut = altOut;
         pinOeN = altOeN;
      end else begin
         pinOut = outBit;
         pinOeN = !dirOut;
      end
   end

endmodule
`default_nettype wire

// [rtl/general_purpose_io_port.sv]
`timescale 1ns/1ps
`default_nettype none

module general_purpose_io_port #(
   parameter int PINS = 16
) (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire logic                     clkEn,
   // apb
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic                          pready,
   output logic                          pslverr,
   output logic [31:0]                   prdata,
   // alternate functions
   input  wire logic [PINS-1:0]          altOut,
   input  wire logic [PINS-1:0]          altOeN,
   // pins
   input  wire logic [PINS-1:0]          pinIn,
   output logic      [PINS-1:0]          pinOut,
   output logic      [PINS-1:0]          pinOeN
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   gpio_port_pkg::gpio_ctrl_t state_q;
   gpio_port_pkg::gpio_ctrl_t state_d;
   gpio_port_pkg::apb_req_t   busReq;
   gpio_port_pkg::apb_rsp_t   busRsp;
   logic [31:0]               readData;
   logic                      wrFunc;
   logic                      wrDir;
   logic                      wrData;
   logic [15:0]               plainOut;

   // ------------------------------------------------------------
   // bus
   // ------------------------------------------------------------
   always_comb begin
      busReq.psel    = psel;
      busReq.penable = penable;
      busReq.pwrite  = pwrite;
      busReq.paddr   = paddr;
      busReq.pwdata  = pwdata;
      pready         = busRsp.pready;
      pslverr        = busRsp.pslverr;
      prdata         = busRsp.prdata;
   end

   gpio_apb_slave u_slave (
      .req      (busReq),
      .rsp      (busRsp),
      .readData (readData),
      .wrFunc   (wrFunc),
      .wrDir    (wrDir),
      .wrData   (wrData),
      .rdHit    ()
   );

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_comb begin
      readData = 32'h0000_0000;
      case (paddr)
         gpio_port_pkg::FUNC_SELECT_OFFSET:
            readData[15:0] = state_q.funcSel;
         gpio_port_pkg::DIR_CONFIG_OFFSET:
            readData[15:0] = state_q.dirCfg;
         gpio_port_pkg::LEVEL_DATA_OFFSET:
            readData[PINS-1:0] = pinIn;
         default:
            readData = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      if (clkEn) begin
         if (wrFunc)
            state_d.funcSel = pwdata[15:0];
         if (wrDir)
            state_d.dirCfg = pwdata[15:0];
         // latch holds written value; only plain outputs show it
         if (wrData)
            state_d.outData = pwdata[15:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q.funcSel <= gpio_port_pkg::FUNC_RESET;
         state_q.dirCfg  <= gpio_port_pkg::DIR_RESET;
         state_q.outData <= gpio_port_pkg::OUT_DATA_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   assign plainOut = state_q.outData;

   for (genvar i = 0; i < PINS; i++) begin : g_pin
      gpio_pin_cell u_cell (
         .funcSel (state_q.funcSel[i]),
         .dirOut  (state_q.dirCfg[i]),
         .outBit  (plainOut[i]),
         .altOut  (altOut[i]),
         .altOeN  (altOeN[i]),
         .pinOut  (pinOut[i]),
         .pinOeN  (pinOeN[i])
      );
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_alt_route: assert property (@(posedge mclk) disable iff (rst)
      (state_q.funcSel[4] |-> pinOut[4] == altOut[4] && pinOeN[4] == altOeN[4]))
      else $error("alternate pin not routed");

   chk_plain_drive: assert property (@(posedge mclk) disable iff (rst)
      (!state_q.funcSel[0] && state_q.dirCfg[0]) |->
         (!pinOeN[0] && pinOut[0] == state_q.outData[0]))
      else $error("plain output not driven");

   chk_plain_input: assert property (@(posedge mclk) disable iff (rst)
      (!state_q.funcSel[1] && !state_q.dirCfg[1]) |-> pinOeN[1])
      else $error("plain input driven");

   chk_plain_mode: assert property (@(posedge mclk) disable iff (rst)
      !state_q.funcSel[2] |-> pinOeN[2] == !state_q.dirCfg[2])
      else $error("plain mode enable wrong");

   chk_dir_ignored: assert property (@(posedge mclk) disable iff (rst)
      (state_q.funcSel[12] && $changed(state_q.dirCfg[12]))
         |-> pinOeN[12] == altOeN[12])
      else $error("direction leaked into alternate pin");

   chk_level_read: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pwrite && paddr == gpio_port_pkg::LEVEL_DATA_OFFSET)
         |-> prdata == {16'h0000, pinIn})
      else $error("level read wrong");

   chk_data_write: assert property (@(posedge mclk) disable iff (rst)
      (clkEn && psel && penable && pwrite
         && paddr == gpio_port_pkg::LEVEL_DATA_OFFSET
         && !state_q.funcSel[0] && state_q.dirCfg[0])
         |=> pinOut[0] == $past(pwdata[0]))
      else $error("write not on output pin");

   chk_upper_zero: assert property (@(posedge mclk) disable iff (rst)
      (psel && penable && !pwrite) |-> prdata[31:16] == 16'h0000)
      else $error("reserved bits not zero");

   chk_freeze: assert property (@(posedge mclk) disable iff (rst)
      !clkEn |=> state_q == $past(state_q))
      else $error("state moved while disabled");

   chk_no_stray: assert property (@(posedge mclk) disable iff (rst)
      !(psel && penable && pwrite) |=> state_q == $past(state_q))
      else $error("state moved without a write");

   // ------------------------------------------------------------
   // bus checks
   // ------------------------------------------------------------
   logic accessNow;
   logic readNow;
   logic mappedAddr;

   always_comb begin
      accessNow  = psel && penable;
      readNow    = accessNow && !pwrite;
      mappedAddr = (paddr == gpio_port_pkg::FUNC_SELECT_OFFSET)
                || (paddr == gpio_port_pkg::DIR_CONFIG_OFFSET)
                || (paddr == gpio_port_pkg::LEVEL_DATA_OFFSET);
   end

   chk_ready_high: assert property (@(posedge mclk) disable iff (rst)
      accessNow |-> pready)
      else $error("access not answered");

   chk_err_unmapped: assert property (@(posedge mclk) disable iff (rst)
      accessNow |-> pslverr == !mappedAddr)
      else $error("error response wrong");

   chk_idle_data: assert property (@(posedge mclk) disable iff (rst)
      !(readNow && mappedAddr) |-> prdata == 32'h0000_0000)
      else $error("read data outside a mapped read");

   chk_read_func: assert property (@(posedge mclk) disable iff (rst)
      (readNow && paddr == gpio_port_pkg::FUNC_SELECT_OFFSET)
         |-> prdata == {16'h0000, state_q.funcSel})
      else $error("function select read wrong");

   chk_read_dir: assert property (@(posedge mclk) disable iff (rst)
      (readNow && paddr == gpio_port_pkg::DIR_CONFIG_OFFSET)
         |-> prdata == {16'h0000, state_q.dirCfg})
      else $error("direction read wrong");

   chk_func_write: assert property (@(posedge mclk) disable iff (rst)
      (clkEn && accessNow && pwrite
         && paddr == gpio_port_pkg::FUNC_SELECT_OFFSET)
         |=> state_q.funcSel == $past(pwdata[15:0]))
      else $error("function select write lost");

   chk_dir_write: assert property (@(posedge mclk) disable iff (rst)
      (clkEn && accessNow && pwrite
         && paddr == gpio_port_pkg::DIR_CONFIG_OFFSET)
         |=> state_q.dirCfg == $past(pwdata[15:0]))
      else $error("direction write lost");

   chk_data_latch: assert property (@(posedge mclk) disable iff (rst)
      (clkEn && accessNow && pwrite
         && paddr == gpio_port_pkg::LEVEL_DATA_OFFSET)
         |=> state_q.outData == $past(pwdata[15:0]))
      else $error("data write lost");

   chk_write_unmapped: assert property (@(posedge mclk) disable iff (rst)
      (accessNow && pwrite && !mappedAddr) |=> state_q == $past(state_q))
      else $error("unmapped write changed state");

   chk_write_frozen: assert property (@(posedge mclk) disable iff (rst)
      (!clkEn && accessNow && pwrite) |=> state_q == $past(state_q))
      else $error("write taken while disabled");

   // first edge out of reset sees the documented start values
   chk_reset_state: assert property (@(posedge mclk) disable iff (rst)
      $fell(rst) |-> state_q.funcSel == gpio_port_pkg::FUNC_RESET
         && state_q.dirCfg == gpio_port_pkg::DIR_RESET
         && state_q.outData == gpio_port_pkg::OUT_DATA_RESET)
      else $error("reset state wrong");

   chk_reset_pins: assert property (@(posedge mclk) disable iff (rst)
      $fell(rst) |-> &pinOeN)
      else $error("pin driven after reset");

   // ------------------------------------------------------------
   // per-pin checks
   // ------------------------------------------------------------
   for (genvar p = 0; p < PINS; p++) begin : g_pin_chk
      chk_pin_alt: assert property (@(posedge mclk) disable iff (rst)
         state_q.funcSel[p]
            |-> pinOut[p] == altOut[p] && pinOeN[p] == altOeN[p])
         else $error("alternate pin not routed");

      chk_pin_mode: assert property (@(posedge mclk) disable iff (rst)
         !state_q.funcSel[p] |-> pinOeN[p] == !state_q.dirCfg[p])
         else $error("plain pin enable wrong");

      chk_pin_out: assert property (@(posedge mclk) disable iff (rst)
         (!state_q.funcSel[p] && state_q.dirCfg[p])
            |-> !pinOeN[p] && pinOut[p] == state_q.outData[p])
         else $error("plain output not driven");

      chk_pin_in: assert property (@(posedge mclk) disable iff (rst)
         (!state_q.funcSel[p] && !state_q.dirCfg[p]) |-> pinOeN[p])
         else $error("plain input driven");

      chk_pin_dir: assert property (@(posedge mclk) disable iff (rst)
         (state_q.funcSel[p] && $changed(state_q.dirCfg[p]))
            |-> pinOeN[p] == altOeN[p])
         else $error("direction leaked into alternate pin");

      chk_pin_rd: assert property (@(posedge mclk) disable iff (rst)
         (readNow && paddr == gpio_port_pkg::LEVEL_DATA_OFFSET)
            |-> prdata[p] == pinIn[p])
         else $error("pin level read wrong");

      chk_pin_wr: assert property (@(posedge mclk) disable iff (rst)
         (clkEn && accessNow && pwrite
            && paddr == gpio_port_pkg::LEVEL_DATA_OFFSET
            && !state_q.funcSel[p] && state_q.dirCfg[p])
            |=> pinOut[p] == $past(pwdata[p]))
         else $error("write not on output pin");

      // a plain input stays released whatever is written to the data word
      chk_pin_keep: assert property (@(posedge mclk) disable iff (rst)
         (clkEn && accessNow && pwrite
            && paddr == gpio_port_pkg::LEVEL_DATA_OFFSET
            && !state_q.funcSel[p] && !state_q.dirCfg[p])
            |=> pinOeN[p])
         else $error("data write drove an input pin");
   end

endmodule
`default_nettype wire

// [testbench/board_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// board: pulls each undriven pin to a chosen level
// ------------------------------------------------------------
module board_pin_model (
   // device side
   input  wire logic [15:0] pinOut,
   input  wire logic [15:0] pinOeN,
   // board side
   input  wire logic [15:0] boardLevel,
   output logic      [15:0] pinIn
);
   // a driven pin shows the device value, a released one the board level
   assign pinIn = (pinOut & ~pinOeN) | (boardLevel & pinOeN);
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   localparam logic [11:0] FSEL = gpio_port_pkg::FUNC_SELECT_OFFSET;
   localparam logic [11:0] DIRC = gpio_port_pkg::DIR_CONFIG_OFFSET;
   localparam logic [11:0] DATA = gpio_port_pkg::LEVEL_DATA_OFFSET;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        clkEn = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        pready;
   logic        pslverr;
   logic [31:0] prdata;
   logic [15:0] altOut = 16'h1234;
   logic [15:0] altOeN = 16'h0F0F;
   logic [15:0] pinIn;
   logic [15:0] pinOut;
   logic [15:0] pinOeN;
   logic [15:0] boardLevel = 16'h3C00;
   logic [15:0] expOut;
   logic [15:0] expOeN;
   logic [31:0] rdData;
   logic        rdErr;
   int          n_mismatch = 0;
   int          tests_run = 0;

   always #5 mclk = ~mclk;

   general_purpose_io_port #(.PINS(16)) general_purpose_io_port_inst (
      .mclk(mclk), .rst(rst), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .altOut(altOut), .altOeN(altOeN), .pinIn(pinIn),
      .pinOut(pinOut), .pinOeN(pinOeN));

   board_pin_model board_pin_model_inst (
      .pinOut(pinOut), .pinOeN(pinOeN), .boardLevel(boardLevel),
      .pinIn(pinIn));

   task automatic check(input string name, input logic [31:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (2000) @(posedge mclk);
      n_mismatch++;
      close_out();
   end

   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      apb(0, FSEL, 0);
      check("fsel reset", 32'h0, rdData);
      check("fsel no err", 32'h0, {31'h0, rdErr});
      apb(0, DIRC, 0);
      check("dir reset", 32'h0, rdData);
      check("oen reset", 32'h0000FFFF, {16'h0, pinOeN});
      $display("test reset done");
      apb(1, DIRC, 32'hFFFF_00FF);
      apb(1, DATA, 32'hFFFF_A5A5);
      check("oen plain", 32'h0000FF00, {16'h0, pinOeN});
      check("out plain", 32'hA5, {24'h0, pinOut[7:0]});
      apb(0, DATA, 0);
      check("data read", 32'h00003CA5, rdData);
      apb(0, DIRC, 0);
      check("dir read", 32'h000000FF, rdData);
      $display("test plain done");
      apb(1, FSEL, 32'hFFFF_F0F0);
      altOut <= 16'hEDCB;
      apb(1, DIRC, 32'hFFFF_F0FF);
      expOeN = (altOeN & 16'hF0F0) | (~16'hF0FF & 16'h0F0F);
      expOut = (altOut & 16'hF0F0) | (16'hA5A5 & 16'h0F0F);
      check("oen alt", {16'h0, expOeN}, {16'h0, pinOeN});
      check("out alt", {16'h0, expOut & ~expOeN},
            {16'h0, pinOut & ~expOeN});
      apb(0, FSEL, 0);
      check("fsel read", 32'h0000F0F0, rdData);
      apb(0, DATA, 0);
      check("data alt", {16'h0, (expOut & ~expOeN) | (boardLevel & expOeN)},
            rdData);
      $display("test alternate done");
      apb(0, 12'h40C, 0);
      check("unmapped err", 32'h1, {31'h0, rdErr});
      check("unmapped data", 32'h0, rdData);
      apb(1, 12'h40C, 32'hFFFF_FFFF);
      check("unmapped wr err", 32'h1, {31'h0, rdErr});
      clkEn <= 1'b0;
      apb(1, DIRC, 32'h0);
      clkEn <= 1'b1;
      apb(0, DIRC, 0);
      check("frozen dir", 32'h0000F0FF, rdData);
      $display("test refusals done");
      close_out();
   end
endmodule
`default_nettype wire
